// ==== common/ccms_pkg.sv ====
// Constants shared by the capture/compare mode-select block.
// Assumes a 16-bit register port with a 4-bit word address.
package ccms_pkg;

  // Register port shape
  localparam int unsigned ADDR_WIDTH = 4;
  localparam int unsigned DATA_WIDTH = 16;

  // Register word addresses
  localparam logic [3:0] OFS_CTRL_LOW     = 4'h0;
  localparam logic [3:0] OFS_CTRL_HIGH    = 4'h1;
  localparam logic [3:0] OFS_CMP_A_LOW    = 4'h2;
  localparam logic [3:0] OFS_CMP_A_HIGH   = 4'h3;
  localparam logic [3:0] OFS_CMP_B_LOW    = 4'h4;
  localparam logic [3:0] OFS_CMP_B_HIGH   = 4'h5;
  localparam logic [3:0] OFS_PERIOD_LOW   = 4'h6;
  localparam logic [3:0] OFS_PERIOD_HIGH  = 4'h7;
  localparam logic [3:0] OFS_CAPTURE_LOW  = 4'h8;
  localparam logic [3:0] OFS_CAPTURE_HIGH = 4'h9;
  localparam logic [3:0] OFS_TIMER_LOW    = 4'ha;
  localparam logic [3:0] OFS_TIMER_HIGH   = 4'hb;
  localparam logic [3:0] OFS_STATUS       = 4'hc;
  localparam logic [3:0] OFS_CLEAR        = 4'hd;
  localparam logic [3:0] OFS_INT_ENABLE   = 4'he;
  localparam logic [3:0] OFS_SOURCE       = 4'hf;

  // Low control word fields
  localparam int unsigned CTRL_ON_BIT     = 15;
  localparam int unsigned CTRL_WIDE_BIT   = 5;
  localparam int unsigned CTRL_CAPSEL_BIT = 4;
  localparam int unsigned CTRL_MODE_LSB   = 0;
  localparam logic [15:0] CTRL_LOW_MASK   = 16'hbfff;
  localparam logic [15:0] CTRL_LOW_RESET  = 16'h0000;

  // High control word fields: 15 postscaler source, 14 retrigger, 11:8 ratio,
  // 7 trigger, 6 single shot, 5 alternate sync, 4:0 sync source
  localparam logic [15:0] CTRL_HIGH_MASK  = 16'hcfff;
  localparam logic [15:0] CTRL_HIGH_RESET = 16'h0000;

  // Other reset values
  localparam logic [31:0] PERIOD_RESET    = 32'hffff_ffff;
  localparam logic [31:0] CMP_RESET       = 32'h0000_0000;
  localparam logic [2:0]  SOURCE_RESET    = 3'h0;

  // Capture mode codes
  localparam logic [3:0] CAP_EDGE_DETECT  = 4'h0;
  localparam logic [3:0] CAP_RISE         = 4'h1;
  localparam logic [3:0] CAP_FALL         = 4'h2;
  localparam logic [3:0] CAP_BOTH         = 4'h3;
  localparam logic [3:0] CAP_RISE_DIV4    = 4'h4;
  localparam logic [3:0] CAP_RISE_DIV16   = 4'h5;

  // Compare mode codes
  localparam logic [3:0] CMP_TIMER        = 4'h0;
  localparam logic [3:0] CMP_SET_HIGH     = 4'h1;
  localparam logic [3:0] CMP_SET_LOW      = 4'h2;
  localparam logic [3:0] CMP_TOGGLE       = 4'h3;
  localparam logic [3:0] CMP_DUAL         = 4'h4;
  localparam logic [3:0] CMP_DUAL_BUF     = 4'h5;
  localparam logic [3:0] CMP_CENTER_BUF   = 4'h6;
  localparam logic [3:0] CMP_VAR_FREQ     = 4'h7;
  localparam logic [3:0] CMP_EXTERNAL     = 4'hf;

  // Status bit positions
  localparam int unsigned STATUS_WIDTH    = 3;
  localparam int unsigned ST_CAPTURE      = 0;
  localparam int unsigned ST_MATCH        = 1;
  localparam int unsigned ST_PERIOD       = 2;

  // Rising edges per capture in the divided modes
  localparam int unsigned CAP_DIV_SMALL   = 4;
  localparam int unsigned CAP_DIV_LARGE   = 16;

  // Compare a time base against a value, on 16 or 32 bits
  function automatic logic ccms_match(input logic [31:0] tb, input logic [31:0] val,
                                      input logic wide);
    ccms_match = wide ? (tb == val) : (tb[15:0] == val[15:0]);
  endfunction : ccms_match

  // Time base value as seen in the selected width
  function automatic logic [31:0] ccms_width(input logic [31:0] v, input logic wide);
    ccms_width = wide ? v : {16'h0000, v[15:0]};
  endfunction : ccms_width

endpackage : ccms_pkg

// ==== logic/ccms_edge_divider.sv ====
// Rising-edge divider for the divided capture modes.
// Assumes edge pulses are one clock long and synchronous to clk_sys.
`timescale 1ns/1ns
`default_nettype none
module ccms_edge_divider
  import ccms_pkg::*;
#(
  parameter int unsigned MAX_DIV = CAP_DIV_LARGE
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Control
  input  wire logic restart,
  input  wire logic large_ratio,
  // Edges in, divided event out
  input  wire logic edge_seen,
  output var  logic fire
);

  if (MAX_DIV < CAP_DIV_LARGE || MAX_DIV > 256) begin : g_bad_div
    $error("ccms_edge_divider: MAX_DIV out of range");
  end

  logic [7:0] count;
  logic [7:0] limit;

  assign limit = large_ratio ? 8'(CAP_DIV_LARGE - 1) : 8'(CAP_DIV_SMALL - 1);
  assign fire  = edge_seen && (count == limit);

  // Restart keeps the count aligned with a fresh mode choice
  always_ff @(posedge clk_sys) begin
    if (rst || restart) begin
      count <= 8'h00;
    end else if (fire) begin
      count <= 8'h00;
    end else if (edge_seen) begin
      count <= count + 8'h01;
    end
  end

  property p_fire_on_last;
    @(posedge clk_sys) disable iff (rst)
    fire |-> (edge_seen && (count == (large_ratio ? 8'h0f : 8'h03)));
  endproperty
  a_fire_on_last: assert property (p_fire_on_last) else $error("divider fired early");

  property p_count_bound;
    @(posedge clk_sys) disable iff (rst)
    count <= 8'h0f;
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("divider count runaway");

endmodule : ccms_edge_divider
`default_nettype wire

// ==== logic/ccms_capture_compare.sv ====
// Capture/compare unit with a 16/32-bit time base and mode selection.
// Assumes capture_in and ext_source are synchronous to clk_sys.
//
// Overview of operation
// R01: Wide bit picks 32-bit else 16-bit base
// R02: Capture bit picks capture, else compare modes
// R03: Capture code 0101 records every sixteenth rise
// R04: Capture code 0100 records every fourth rise
// R05: Capture code 0011 records both edges
// R06: Capture code 0010 records falling edges only
// R07: Capture code 0001 records rising edges only
// R08: Capture code 0000 edge detect, both edges
// R09: Compare code 1111 drives selected external source
// R10: Compare code 0111 variable frequency, first instance
// R11: Compare code 0110 buffered centre aligned, first instance
// R12: Compare code 0101 dual edge, buffered values
// R13: Compare code 0100 dual edge, A sets, B clears
// R14: Compare code 0011 toggles output on match
// R15: Compare code 0010 drives output low on match
// R16: Compare code 0001 drives output high on match
// R17: Compare code 0000 timer only, output off
// R18: Second control word layout, resets to zero
// R19: Software never programs reserved mode codes
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module ccms_capture_compare
  import ccms_pkg::*;
#(
  parameter int unsigned FIRST_INSTANCE = 1
) (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // Register port
  input  wire logic [ADDR_WIDTH-1:0] reg_addr,
  input  wire logic [DATA_WIDTH-1:0] reg_wr_data,
  input  wire logic                  reg_wr_en,
  input  wire logic                  reg_rd_en,
  output var  logic [DATA_WIDTH-1:0] reg_rd_data,
  // Pins
  input  wire logic                  capture_in,
  input  wire logic [7:0]            ext_source,
  output var  logic                  compare_out,
  output var  logic                  compare_oe,
  // Interrupt
  output var  logic                  irq
);

  if (FIRST_INSTANCE > 1) begin : g_bad_instance
    $error("ccms_capture_compare: FIRST_INSTANCE must be 0 or 1");
  end

  logic [15:0]             ctrl_low;
  logic [15:0]             ctrl_high;
  logic [31:0]             cmp_a;
  logic [31:0]             cmp_b;
  logic [31:0]             shadow_a;
  logic [31:0]             shadow_b;
  logic [31:0]             period;
  logic [31:0]             timer_value;
  logic [31:0]             capture_value;
  logic [2:0]              input_source_select;
  logic [STATUS_WIDTH-1:0] status;
  logic [STATUS_WIDTH-1:0] int_enable;
  logic                    capture_in_q;
  logic [15:0]             freq_acc;

  logic                    module_on;
  logic                    wide_time_base_select;
  logic                    capture_function_select;
  logic [3:0]              function_mode_code;
  logic                    rise;
  logic                    fall;
  logic                    divided_fire;
  logic                    capture_fire;
  logic                    period_hit;
  logic [31:0]             act_a;
  logic [31:0]             act_b;
  logic                    match_a;
  logic                    match_b;
  logic                    buffered;
  logic                    wr_ctrl_low;
  logic [16:0]             freq_sum;
  logic                    next_out;
  logic                    next_oe;
  logic [STATUS_WIDTH-1:0] events;
  logic [STATUS_WIDTH-1:0] clear_bits;

  assign module_on               = ctrl_low[CTRL_ON_BIT];
  assign wide_time_base_select   = ctrl_low[CTRL_WIDE_BIT];
  assign capture_function_select = ctrl_low[CTRL_CAPSEL_BIT];
  assign function_mode_code      = ctrl_low[CTRL_MODE_LSB +: 4];
  assign wr_ctrl_low             = reg_wr_en && (reg_addr == OFS_CTRL_LOW);

  // Register writes
  // R18 second control word
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_low            <= CTRL_LOW_RESET;
      ctrl_high           <= CTRL_HIGH_RESET;
      cmp_a               <= CMP_RESET;
      cmp_b               <= CMP_RESET;
      period              <= PERIOD_RESET;
      input_source_select <= SOURCE_RESET;
      int_enable          <= '0;
    end else if (reg_wr_en) begin
      unique case (reg_addr)
        OFS_CTRL_LOW:    ctrl_low            <= reg_wr_data & CTRL_LOW_MASK;
        OFS_CTRL_HIGH:   ctrl_high           <= reg_wr_data & CTRL_HIGH_MASK;
        OFS_CMP_A_LOW:   cmp_a[15:0]         <= reg_wr_data;
        OFS_CMP_A_HIGH:  cmp_a[31:16]        <= reg_wr_data;
        OFS_CMP_B_LOW:   cmp_b[15:0]         <= reg_wr_data;
        OFS_CMP_B_HIGH:  cmp_b[31:16]        <= reg_wr_data;
        OFS_PERIOD_LOW:  period[15:0]        <= reg_wr_data;
        OFS_PERIOD_HIGH: period[31:16]       <= reg_wr_data;
        OFS_INT_ENABLE:  int_enable          <= reg_wr_data[STATUS_WIDTH-1:0];
        OFS_SOURCE:      input_source_select <= reg_wr_data[2:0];
        default: ;
      endcase
    end
  end

  // Time base
  assign period_hit = module_on && ccms_match(timer_value, period, wide_time_base_select);

  // R01 width of count
  always_ff @(posedge clk_sys) begin
    if (rst || !module_on) begin
      timer_value <= 32'h0000_0000;
    end else if (period_hit) begin
      timer_value <= 32'h0000_0000;
    end else begin
      timer_value <= ccms_width(timer_value + 32'h0000_0001, wide_time_base_select);
    end
  end

  // Capture path
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      capture_in_q <= 1'b0;
    end else begin
      capture_in_q <= capture_in;
    end
  end

  assign rise = capture_in && !capture_in_q;
  assign fall = !capture_in && capture_in_q;

  // R03 sixteenth rise
  // R04 fourth rise
  ccms_edge_divider #(
    .MAX_DIV (CAP_DIV_LARGE)
  ) u_divider (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .restart     (wr_ctrl_low || !module_on),
    .large_ratio (function_mode_code == CAP_RISE_DIV16),
    .edge_seen   (rise),
    .fire        (divided_fire)
  );

  // R02 capture selected
  always_comb begin
    capture_fire = 1'b0;
    if (module_on && capture_function_select) begin
      unique case (function_mode_code)
        // R08 edge detect
        CAP_EDGE_DETECT: capture_fire = rise || fall;
        // R07 rising only
        CAP_RISE:        capture_fire = rise;
        // R06 falling only
        CAP_FALL:        capture_fire = fall;
        // R05 both edges
        CAP_BOTH:        capture_fire = rise || fall;
        CAP_RISE_DIV4,
        CAP_RISE_DIV16:  capture_fire = divided_fire;
        // Reserved codes capture nothing
        default:         capture_fire = 1'b0;
      endcase
    end
  end

  // R01 captured width
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      capture_value <= 32'h0000_0000;
    end else if (capture_fire) begin
      capture_value <= ccms_width(timer_value, wide_time_base_select);
    end
  end

  // Compare path
  // R12 buffered values
  assign buffered = (function_mode_code == CMP_DUAL_BUF) ||
                    (function_mode_code == CMP_CENTER_BUF);
  assign act_a    = buffered ? shadow_a : cmp_a;
  assign act_b    = buffered ? shadow_b : cmp_b;
  assign match_a  = module_on && ccms_match(timer_value, act_a, wide_time_base_select);
  assign match_b  = module_on && ccms_match(timer_value, act_b, wide_time_base_select);

  // New values reach buffered modes only at a period rollover or while off,
  // so a half-written 32-bit value never takes effect mid-period
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shadow_a <= CMP_RESET;
      shadow_b <= CMP_RESET;
    end else if (period_hit || !module_on) begin
      shadow_a <= cmp_a;
      shadow_b <= cmp_b;
    end
  end

  // R10 pulse accumulator
  assign freq_sum = {1'b0, freq_acc} + {1'b0, cmp_a[15:0]};

  always_ff @(posedge clk_sys) begin
    if (rst || !module_on) begin
      freq_acc <= 16'h0000;
    end else begin
      freq_acc <= freq_sum[15:0];
    end
  end

  always_comb begin
    next_out = compare_out;
    next_oe  = 1'b0;
    if (module_on && !capture_function_select) begin
      next_oe = 1'b1;
      unique case (function_mode_code)
        // R17 timer only
        CMP_TIMER: begin
          next_oe  = 1'b0;
          next_out = 1'b0;
        end
        // R16 drive high
        CMP_SET_HIGH: if (match_a) next_out = 1'b1;
        // R15 drive low
        CMP_SET_LOW:  if (match_a) next_out = 1'b0;
        // R14 toggle
        CMP_TOGGLE:   if (match_a) next_out = !compare_out;
        // R13 set and clear
        // R12 buffered dual edge
        // R11 centre aligned
        CMP_DUAL, CMP_DUAL_BUF, CMP_CENTER_BUF: begin
          if (function_mode_code == CMP_CENTER_BUF && FIRST_INSTANCE == 0) begin
            next_oe  = 1'b0;
            next_out = 1'b0;
          end else if (match_b) begin
            next_out = 1'b0;
          end else if (match_a) begin
            next_out = 1'b1;
          end
        end
        // R10 carry pulse
        CMP_VAR_FREQ: begin
          next_oe  = (FIRST_INSTANCE != 0);
          next_out = (FIRST_INSTANCE != 0) && freq_sum[16];
        end
        // R09 external source
        CMP_EXTERNAL: next_out = ext_source[input_source_select];
        // R19 reserved codes keep the pin released
        default: begin
          next_oe  = 1'b0;
          next_out = 1'b0;
        end
      endcase
    end else begin
      next_out = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      compare_out <= 1'b0;
      compare_oe  <= 1'b0;
    end else begin
      compare_out <= next_out;
      compare_oe  <= next_oe;
    end
  end

  // Interrupt status: a new event wins over a clear in the same cycle
  assign events[ST_CAPTURE] = capture_fire;
  assign events[ST_MATCH]   = match_a && !capture_function_select;
  assign events[ST_PERIOD]  = period_hit;
  assign clear_bits = (reg_wr_en && reg_addr == OFS_CLEAR) ?
                      reg_wr_data[STATUS_WIDTH-1:0] : '0;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status <= '0;
    end else begin
      status <= (status & ~clear_bits) | events;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & int_enable);
    end
  end

  // Read port; unmapped and write-only words read as zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rd_data <= '0;
    end else if (reg_rd_en) begin
      unique case (reg_addr)
        OFS_CTRL_LOW:     reg_rd_data <= ctrl_low;
        OFS_CTRL_HIGH:    reg_rd_data <= ctrl_high;
        OFS_CMP_A_LOW:    reg_rd_data <= cmp_a[15:0];
        OFS_CMP_A_HIGH:   reg_rd_data <= cmp_a[31:16];
        OFS_CMP_B_LOW:    reg_rd_data <= cmp_b[15:0];
        OFS_CMP_B_HIGH:   reg_rd_data <= cmp_b[31:16];
        OFS_PERIOD_LOW:   reg_rd_data <= period[15:0];
        OFS_PERIOD_HIGH:  reg_rd_data <= period[31:16];
        OFS_CAPTURE_LOW:  reg_rd_data <= capture_value[15:0];
        OFS_CAPTURE_HIGH: reg_rd_data <= capture_value[31:16];
        OFS_TIMER_LOW:    reg_rd_data <= timer_value[15:0];
        OFS_TIMER_HIGH:   reg_rd_data <= timer_value[31:16];
        OFS_STATUS:       reg_rd_data <= {13'h0000, status};
        OFS_INT_ENABLE:   reg_rd_data <= {13'h0000, int_enable};
        OFS_SOURCE:       reg_rd_data <= {13'h0000, input_source_select};
        default:          reg_rd_data <= '0;
      endcase
    end
  end

  // Checks
  property p_narrow_base;
    @(posedge clk_sys) disable iff (rst)
    !wide_time_base_select |=> (timer_value[31:16] == 16'h0000);
  endproperty
  a_narrow_base: assert property (p_narrow_base) else $error("upper half counts in 16-bit mode"); // R01

  property p_capture_no_drive;
    @(posedge clk_sys) disable iff (rst)
    capture_function_select |=> !compare_oe;
  endproperty
  a_capture_no_drive: assert property (p_capture_no_drive) else $error("pin driven in capture"); // R02

  property p_rise_capture;
    @(posedge clk_sys) disable iff (rst)
    (module_on && capture_function_select && function_mode_code == CAP_RISE && rise)
      |=> status[ST_CAPTURE] && (capture_value == ccms_width($past(timer_value), $past(wide_time_base_select)));
  endproperty
  a_rise_capture: assert property (p_rise_capture) else $error("rising edge not captured"); // R07

  property p_fall_only;
    @(posedge clk_sys) disable iff (rst)
    (capture_function_select && function_mode_code == CAP_FALL && rise) |-> !capture_fire;
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("rise captured in falling mode"); // R06

  property p_both_edges;
    @(posedge clk_sys) disable iff (rst)
    (module_on && capture_function_select && function_mode_code == CAP_BOTH && fall)
      |-> capture_fire;
  endproperty
  a_both_edges: assert property (p_both_edges) else $error("falling edge missed"); // R05

  property p_set_high;
    @(posedge clk_sys) disable iff (rst)
    (module_on && !capture_function_select && function_mode_code == CMP_SET_HIGH && match_a)
      |=> compare_out && compare_oe;
  endproperty
  a_set_high: assert property (p_set_high) else $error("output not high on match"); // R16

  property p_set_low;
    @(posedge clk_sys) disable iff (rst)
    (module_on && !capture_function_select && function_mode_code == CMP_SET_LOW && match_a)
      |=> !compare_out;
  endproperty
  a_set_low: assert property (p_set_low) else $error("output not low on match"); // R15

  property p_toggle;
    @(posedge clk_sys) disable iff (rst)
    (module_on && !capture_function_select && function_mode_code == CMP_TOGGLE && match_a)
      |=> compare_out != $past(compare_out);
  endproperty
  a_toggle: assert property (p_toggle) else $error("output did not toggle"); // R14

  property p_timer_only;
    @(posedge clk_sys) disable iff (rst)
    (!capture_function_select && function_mode_code == CMP_TIMER) |=> !compare_oe && !compare_out;
  endproperty
  a_timer_only: assert property (p_timer_only) else $error("output active in timer mode"); // R17

  property p_dual_clear;
    @(posedge clk_sys) disable iff (rst)
    (module_on && !capture_function_select && function_mode_code == CMP_DUAL && match_b)
      |=> !compare_out;
  endproperty
  a_dual_clear: assert property (p_dual_clear) else $error("second match did not clear"); // R13

  property p_external;
    @(posedge clk_sys) disable iff (rst)
    (module_on && !capture_function_select && function_mode_code == CMP_EXTERNAL)
      |=> compare_out == $past(ext_source[input_source_select]);
  endproperty
  a_external: assert property (p_external) else $error("external source not followed"); // R09

  property p_irq_level;
    @(posedge clk_sys) disable iff (rst)
    ##1 irq == $past(|(status & int_enable));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  c_div16: cover property (@(posedge clk_sys) disable iff (rst)
    capture_function_select && function_mode_code == CAP_RISE_DIV16 && capture_fire);
  c_toggle: cover property (@(posedge clk_sys) disable iff (rst)
    !capture_function_select && function_mode_code == CMP_TOGGLE && match_a);
  c_dual_buf: cover property (@(posedge clk_sys) disable iff (rst)
    !capture_function_select && function_mode_code == CMP_DUAL_BUF && match_b);
  c_irq: cover property (@(posedge clk_sys) disable iff (rst) $rose(irq));

endmodule : ccms_capture_compare
`default_nettype wire

// ==== verification/ccms_pin_model.sv ====
// Pin-side partner: drives the capture pin and the external sources.
// Assumes the caller steps it from a process that follows clk_sys.
`timescale 1ns/1ns
`default_nettype none
module ccms_pin_model (
  // Clock
  input  wire logic       clk_sys,
  // Pins toward the block
  output var  logic       capture_in,
  output var  logic [7:0] ext_source
);
  // Only source 2 is high, so a wrong source index shows as a low pin
  initial begin
    capture_in = 1'b0;
    ext_source = 8'h04;
  end

  task automatic drive(input logic v);
    @(posedge clk_sys);
    capture_in <= v;
  endtask : drive
endmodule : ccms_pin_model
`default_nettype wire

// ==== verification/capture_compare_mode_select_tb_top.sv ====
// Self-checking bench for the capture/compare mode-select block.
// Assumes the pin model above and the register map of the package.
`timescale 1ns/1ns
`default_nettype none
module capture_compare_mode_select_tb_top
  import ccms_pkg::*;
;
  logic                  clk_sys = 1'b0;
  logic                  rst;
  logic [ADDR_WIDTH-1:0] reg_addr;
  logic [DATA_WIDTH-1:0] reg_wr_data;
  logic                  reg_wr_en;
  logic                  reg_rd_en;
  logic [DATA_WIDTH-1:0] reg_rd_data;
  logic                  capture_in;
  logic [7:0]            ext_source;
  logic                  compare_out;
  logic                  compare_oe;
  logic                  irq;
  logic [15:0]           v;
  logic [31:0]           r;
  int                    fail_count = 0;
  int                    n_compared = 0;
  // Row: control word, rises or cycles, expected bits
  logic [31:0] rows [0:21] = '{
    32'h8000_0900, 32'h8021_0901, 32'h8001_0903, 32'h8002_0901, 32'h8003_0903,
    32'h8003_1d01, 32'h8004_0903, 32'h8004_0f01, 32'h8005_0903, 32'h8005_0f01,
    32'h8006_0903, 32'h8006_0f01, 32'h8007_0901, 32'h800f_0903,
    32'h8010_0103, 32'h8011_0102, 32'h8012_0101, 32'h8013_0103,
    32'h8014_0300, 32'h8014_0402, 32'h8015_0f00, 32'h8015_1002};

  always #50 clk_sys = ~clk_sys;

  ccms_capture_compare #(.FIRST_INSTANCE(1)) dut (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .capture_in(capture_in), .ext_source(ext_source), .compare_out(compare_out),
    .compare_oe(compare_oe), .irq(irq));

  ccms_pin_model pin (.clk_sys(clk_sys), .capture_in(capture_in), .ext_source(ext_source));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr_en   <= 1'b1;
    reg_addr    <= a;
    reg_wr_data <= d;
    @(posedge clk_sys);
    reg_wr_en   <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    #1;
    d = reg_rd_data;
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic end_sim;
    if (fail_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  // A hang counts as a mismatch
  initial begin
    repeat (60000) @(posedge clk_sys);
    fail_count++;
    end_sim();
  end

  initial begin
    rst         <= 1'b1;
    reg_addr    <= '0;
    reg_wr_data <= '0;
    reg_wr_en   <= 1'b0;
    reg_rd_en   <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd(OFS_CTRL_HIGH, v);
    chk("ctrl_high reset", 16'h0000, v);
    wr(OFS_CTRL_HIGH, 16'hffff);
    rd(OFS_CTRL_HIGH, v);
    chk("ctrl_high mask", 16'hcfff, v);
    // High compare A word only matters in the 32-bit base
    wr(OFS_CMP_A_LOW, 16'h0005);
    wr(OFS_CMP_A_HIGH, 16'h0001);
    wr(OFS_CMP_B_LOW, 16'h000c);
    wr(OFS_PERIOD_LOW, 16'h0013);
    wr(OFS_SOURCE, 16'h0002);
    // only documented codes in the table
    for (int i = 0; i < 22; i++) begin
      r = rows[i];
      wr(OFS_CTRL_LOW, 16'h0000);
      wr(OFS_CLEAR, 16'h0007);
      wr(OFS_CTRL_LOW, r[31:16]);
      if (r[20]) begin
        repeat (r[15:8] - 8'h01) begin
          pin.drive(1'b1);
          pin.drive(1'b0);
        end
        wr(OFS_CLEAR, 16'h0007);
        pin.drive(1'b1);
        tick(3);
        rd(OFS_STATUS, v);
        chk("capture on rise", {15'h0, r[1]}, v & 16'h0001);
        wr(OFS_CLEAR, 16'h0007);
        pin.drive(1'b0);
        tick(3);
        rd(OFS_STATUS, v);
        chk("capture on fall", {15'h0, r[0]}, v & 16'h0001);
      end else begin
        tick(r[15:8]);
        chk("compare pin", {14'h0, r[1:0]}, {14'h0, compare_out, compare_oe});
      end
    end
    // Interrupt raised, masked and cleared
    wr(OFS_INT_ENABLE, 16'h0001);
    wr(OFS_CTRL_LOW, 16'h0000);
    wr(OFS_CLEAR, 16'h0007);
    wr(OFS_CTRL_LOW, 16'h8011);
    pin.drive(1'b1);
    tick(3);
    chk("irq raised", 16'h0001, {15'h0, irq});
    rd(OFS_CAPTURE_LOW, v);
    chk("capture value", 16'h0001, v);
    rd(OFS_CAPTURE_HIGH, v);
    chk("capture upper half", 16'h0000, v);
    wr(OFS_INT_ENABLE, 16'h0000);
    tick(2);
    chk("irq masked", 16'h0000, {15'h0, irq});
    wr(OFS_INT_ENABLE, 16'h0001);
    tick(2);
    chk("irq unmasked", 16'h0001, {15'h0, irq});
    wr(OFS_CLEAR, 16'h0001);
    tick(2);
    chk("irq cleared", 16'h0000, {15'h0, irq});
    rd(OFS_CLEAR, v);
    chk("clear reads zero", 16'h0000, v);
    // Half-scale step gives a carry pulse every second cycle
    wr(OFS_CTRL_LOW, 16'h0000);
    wr(OFS_CMP_A_LOW, 16'h8000);
    wr(OFS_CTRL_LOW, 16'h8007);
    tick(2);
    chk("carry pulse high", 16'h0003, {14'h0, compare_out, compare_oe});
    tick(1);
    chk("carry pulse low", 16'h0001, {14'h0, compare_out, compare_oe});
    // A low source must show through, so the index is really used
    wr(OFS_SOURCE, 16'h0001);
    wr(OFS_CTRL_LOW, 16'h800f);
    tick(2);
    chk("external low", 16'h0001, {14'h0, compare_out, compare_oe});
    // Reset in mid-run
    wr(OFS_CTRL_LOW, 16'h8001);
    @(posedge clk_sys);
    rst <= 1'b1;
    tick(2);
    chk("pins in reset", 16'h0000, {13'h0, compare_out, compare_oe, irq});
    @(posedge clk_sys);
    rst <= 1'b0;
    rd(OFS_CTRL_HIGH, v);
    chk("ctrl_high after reset", 16'h0000, v);
    rd(OFS_CTRL_LOW, v);
    chk("ctrl_low after reset", 16'h0000, v);
    end_sim();
  end
endmodule : capture_compare_mode_select_tb_top
`default_nettype wire
